// >>> rtl/vfdmx_top.sv
// vfd mux command port: 16-bit host serial link plus tube driver multiplex engine
// assumes host clock stops outside frames and chip select stays high at least 4 clk cycles
`timescale 1ns/1ps
`include "vfdmx_map.svh"

module vfdmx_top
	import vfdmx_pkg::*;
(
	// system
	input  wire logic clk,
	input  wire logic rst,
	// host serial link
	input  wire logic host_sclk,
	input  wire logic host_cs_n,
	input  wire logic host_din,
	output logic      host_dout,
	// power control
	input  wire logic shutdown,
	// tube driver
	output logic      tube_shift_clock,
	output logic      tube_serial_data,
	output logic      tube_latch_load,
	output logic      tube_blank
);

	typedef struct packed {
		logic             cs_meta;
		logic             cs_sync;
		logic             cs_prev;
		logic             sd_meta;
		logic             sd_sync;
		logic             sd_prev;
		logic [15:0]      cmd;
		logic             exec;
		vfdmx_cfg_s       cfg;
		logic [3:0]       osc_cnt;
		logic [4:0]       sub;
		logic [3:0]       slot;
		logic [5:0]       grid;
		logic [5:0]       pat_grid;
		vfdmx_sh_e        sh;
		logic [6:0]       pos;
		logic [1:0]       ph;
		logic [1:0]       blank_hold;
		logic             shift_clock;
		logic             serial_data;
		logic             latch_load;
		logic             blank;
	} vfdmx_sys_s;

	typedef struct packed {
		logic [15:0]      sreg;
		vfdmx_cfg_s       cfg_meta;
		vfdmx_cfg_s       cfg_sync;
	} vfdmx_lnk_s;

	vfdmx_sys_s s;
	vfdmx_sys_s next_s;
	vfdmx_lnk_s l;
	vfdmx_lnk_s next_l;
	logic       started;

	function automatic logic [7:0] vfdmx_clamp(input logic [7:0] d, input logic [7:0] lim);
		vfdmx_clamp = (d > lim) ? lim : d;
	endfunction

	function automatic logic [7:0] vfdmx_reg_read(input logic [6:0] a, input vfdmx_cfg_s c);
		if (a == `VFDMX_ADDR_POL) begin
			vfdmx_reg_read = c.polarity;
		end else if (a == `VFDMX_ADDR_BRIGHT) begin
			vfdmx_reg_read = c.brightness;
		end else if (a == `VFDMX_ADDR_GRID) begin
			vfdmx_reg_read = c.grid;
		end else if (a == `VFDMX_ADDR_LIMIT) begin
			vfdmx_reg_read = c.limit;
		end else begin
			vfdmx_reg_read = 8'h00;
		end
	endfunction

	// last unblanked slot: code k unblanks slots 1..k+1, code 15 acts as 14
	function automatic logic [4:0] vfdmx_bright_top(input logic [7:0] b);
		logic [3:0] k;
		k = (b[3:0] > `VFDMX_BRIGHT_TOP) ? `VFDMX_BRIGHT_TOP : b[3:0];
		vfdmx_bright_top = {1'b0, k} + 5'h01;
	endfunction

	// ---------------- link domain ----------------
	logic [15:0] eff;

	always_comb begin
		next_l = l;
		// config is quasi-static: written a whole frame before any read of it
		next_l.cfg_meta = s.cfg;
		next_l.cfg_sync = l.cfg_meta;
		// read result is folded in at the first selected edge after the read frame
		if (!started && l.sreg[`VFDMX_RW_BIT]) begin
			eff = {l.sreg[15:8], vfdmx_reg_read(l.sreg[`VFDMX_ADDR_HI:`VFDMX_ADDR_LO], l.cfg_sync)};
		end else begin
			eff = l.sreg;
		end
		if (!host_cs_n) begin
			next_l.sreg = {eff[14:0], host_din};
		end
	end

	always_ff @(posedge host_sclk or posedge rst) begin
		if (rst) begin
			l <= '0;
		end else begin
			l <= next_l;
		end
	end

	// frame-start marker: cleared by chip select itself since the link clock stops
	always_ff @(posedge host_sclk or posedge host_cs_n or posedge rst) begin
		if (rst || host_cs_n) begin
			started <= 1'b0;
		end else begin
			started <= 1'b1;
		end
	end

	// changes on falling edge so the host samples a settled bit; first bit is stale
	always_ff @(negedge host_sclk or posedge rst) begin
		if (rst) begin
			host_dout <= 1'b0;
		end else begin
			host_dout <= l.sreg[15];
		end
	end

	// ---------------- system domain ----------------
	logic       osc_tick;
	logic       slot_end;
	logic       period_start;
	logic       wr_grid;
	logic       sd_exit;
	logic [6:0] wa;
	logic [7:0] wd;
	logic       blank_active;

	always_comb begin
		next_s = s;
		wr_grid = 1'b0;
		wa = s.cmd[`VFDMX_ADDR_HI:`VFDMX_ADDR_LO];
		wd = s.cmd[`VFDMX_DATA_HI:`VFDMX_DATA_LO];
		next_s.cs_meta = host_cs_n;
		next_s.cs_sync = s.cs_meta;
		next_s.cs_prev = s.cs_sync;
		next_s.sd_meta = shutdown;
		next_s.sd_sync = s.sd_meta;
		next_s.sd_prev = s.sd_sync;
		sd_exit = s.sd_prev && !s.sd_sync;
		next_s.exec = 1'b0;
		// shift register is frozen while deselected, so taking it here is safe
		if (s.cs_sync && !s.cs_prev) begin
			next_s.cmd = l.sreg;
			next_s.exec = 1'b1;
		end
		if (s.exec && !s.cmd[`VFDMX_RW_BIT]) begin
			if (wa == `VFDMX_ADDR_NOOP) begin
				next_s.cfg = s.cfg;
			end else if (wa == `VFDMX_ADDR_POL) begin
				next_s.cfg.polarity = wd & `VFDMX_POL_MASK;
			end else if (wa == `VFDMX_ADDR_BRIGHT) begin
				next_s.cfg.brightness = wd;
			end else if (wa == `VFDMX_ADDR_GRID) begin
				next_s.cfg.grid = vfdmx_clamp(wd, `VFDMX_GRID_MAX);
				wr_grid = 1'b1;
			end else if (wa == `VFDMX_ADDR_LIMIT) begin
				next_s.cfg.limit = vfdmx_clamp(wd, `VFDMX_LIMIT_MAX);
			end
		end

		osc_tick = (s.osc_cnt == 4'(`VFDMX_OSC_DIV - 1));
		slot_end = osc_tick && (s.sub == 5'(`VFDMX_SLOT_OSC - 1));
		period_start = slot_end && (s.slot == `VFDMX_LAST_SLOT);
		next_s.osc_cnt = osc_tick ? 4'h0 : s.osc_cnt + 4'h1;

		if (s.sd_sync) begin
			// park just before a period start so release begins at grid 0
			next_s.osc_cnt = 4'(`VFDMX_OSC_DIV - 1);
			next_s.sub = 5'(`VFDMX_SLOT_OSC - 1);
			next_s.slot = `VFDMX_LAST_SLOT;
			next_s.grid = s.cfg.grid[5:0];
			next_s.sh = VFDMX_SH_IDLE;
			next_s.shift_clock = 1'b1;
			next_s.latch_load = 1'b0;
		end else begin
			if (period_start) begin
				next_s.sub = 5'h00;
				next_s.slot = 4'h0;
				next_s.grid = (s.grid >= s.cfg.grid[5:0]) ? 6'h00 : s.grid + 6'h01;
				next_s.latch_load = 1'b1;
			end else if (slot_end) begin
				next_s.sub = 5'h00;
				next_s.slot = s.slot + 4'h1;
			end else if (osc_tick) begin
				next_s.sub = s.sub + 5'h01;
			end
			if (osc_tick && s.slot == 4'h0 && s.sub == 5'(`VFDMX_SHIFT_OSC - 1)) begin
				next_s.latch_load = 1'b0;
			end
			case (s.sh)
				VFDMX_SH_IDLE: begin
					if (slot_end && s.slot == 4'h0) begin
						// pattern for the grid after the one now lit
						next_s.sh = VFDMX_SH_RUN;
						next_s.pos = 7'h00;
						next_s.ph = 2'h0;
						next_s.pat_grid = (s.grid >= s.cfg.grid[5:0]) ? 6'h00 : s.grid + 6'h01;
					end
				end
				VFDMX_SH_RUN: begin
					if (osc_tick) begin
						next_s.ph = s.ph + 2'h1;
						if (s.ph == 2'h0) begin
							next_s.shift_clock = 1'b0;
							next_s.serial_data = (s.pos == {1'b0, s.pat_grid});
						end else if (s.ph == 2'h2) begin
							next_s.shift_clock = 1'b1;
						end else if (s.ph == 2'h3) begin
							if (s.pos >= s.cfg.limit[6:0]) begin
								next_s.sh = VFDMX_SH_IDLE;
							end else begin
								next_s.pos = s.pos + 7'h01;
							end
						end
					end
				end
				default: begin
					next_s.sh = VFDMX_SH_IDLE;
				end
			endcase
		end

		// driver latches may hold junk after a grid write or wake-up
		if (period_start && s.blank_hold != 2'h0) begin
			next_s.blank_hold = s.blank_hold - 2'h1;
		end
		if (wr_grid || sd_exit) begin
			next_s.blank_hold = `VFDMX_BLANK_CYCLES;
		end
		blank_active = s.sd_sync || (s.blank_hold != 2'h0) || (s.slot == 4'h0)
			|| ({1'b0, s.slot} > vfdmx_bright_top(s.cfg.brightness));
		next_s.blank = blank_active ^ s.cfg.polarity[`VFDMX_POL_BIT];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.cs_meta <= 1'b1;
			s.cs_sync <= 1'b1;
			s.cs_prev <= 1'b1;
			s.cfg.brightness <= `VFDMX_RST_BRIGHT;
			s.cfg.grid <= `VFDMX_RST_GRID;
			s.cfg.limit <= `VFDMX_RST_LIMIT;
			s.cfg.polarity <= `VFDMX_RST_POL;
			s.sh <= VFDMX_SH_IDLE;
			s.shift_clock <= 1'b1;
			s.blank <= 1'b1;
			s.blank_hold <= `VFDMX_BLANK_CYCLES;
		end else begin
			s <= next_s;
		end
	end

	assign tube_shift_clock = s.shift_clock;
	assign tube_serial_data = s.serial_data;
	assign tube_latch_load = s.latch_load;
	assign tube_blank = s.blank;

	// ---------------- checks ----------------
	a_latch_copy: assert property (@(posedge clk) disable iff (rst)
		(s.cs_sync && !s.cs_prev) |=> (s.cmd == $past(l.sreg)) && s.exec)
		else $error("command latch did not take shift register");
	a_grid_clamp: assert property (@(posedge clk) disable iff (rst)
		(s.exec && !s.cmd[15] && s.cmd[14:8] == 7'h03) |=> s.cfg.grid == vfdmx_clamp($past(s.cmd[7:0]), 8'h2F))
		else $error("grid count not stored clamped");
	a_limit_clamp: assert property (@(posedge clk) disable iff (rst)
		(s.exec && !s.cmd[15] && s.cmd[14:8] == 7'h0E) |=> s.cfg.limit == vfdmx_clamp($past(s.cmd[7:0]), 8'h53))
		else $error("bit-count limit not stored clamped");
	a_noop_ignored: assert property (@(posedge clk) disable iff (rst)
		(s.exec && s.cmd == 16'h0000) |=> $stable(s.cfg))
		else $error("no-op write changed a register");
	a_data_on_fall: assert property (@(posedge clk) disable iff (rst)
		$changed(tube_serial_data) |-> $fell(tube_shift_clock))
		else $error("tube data changed without clock fall");
	a_clock_half: assert property (@(posedge clk) disable iff (rst)
		$fell(tube_shift_clock) |-> $past(tube_shift_clock, 20))
		else $error("tube clock high phase too short");
	a_load_start: assert property (@(posedge clk) disable iff (rst)
		$rose(tube_latch_load) |-> s.slot == 4'h0 && s.sub == 5'h00 ##40 !tube_latch_load)
		else $error("latch load not a grid-start pulse");
	a_first_blank: assert property (@(posedge clk) disable iff (rst)
		(s.slot == 4'h0 && $past(s.slot) == 4'h0) |-> tube_blank == !$past(s.cfg.polarity[`VFDMX_POL_BIT]))
		else $error("first slot of grid period not blanked");
	a_shutdown_blank: assert property (@(posedge clk) disable iff (rst)
		(s.sd_sync && $past(s.sd_sync)) |-> tube_blank == !$past(s.cfg.polarity[1]) && !tube_latch_load)
		else $error("tube driver not disabled in shutdown");
	a_grid_wrap: assert property (@(posedge clk) disable iff (rst)
		(period_start && !s.sd_sync && s.grid >= s.cfg.grid[5:0]) |=> s.grid == 6'h00)
		else $error("grid index did not wrap to first grid");

endmodule

// >>> rtl/vfdmx_map.svh
// register map, field positions, reset values and timing counts of the vfd mux command port
// assumes a 40 MHz system clock and a multiplex oscillator derived from it
`ifndef VFDMX_MAP_SVH
`define VFDMX_MAP_SVH
// frame fields
`define VFDMX_RW_BIT        15
`define VFDMX_ADDR_HI       14
`define VFDMX_ADDR_LO       8
`define VFDMX_DATA_HI       7
`define VFDMX_DATA_LO       0
// register addresses
`define VFDMX_ADDR_NOOP     7'h00
`define VFDMX_ADDR_POL      7'h01
`define VFDMX_ADDR_BRIGHT   7'h02
`define VFDMX_ADDR_GRID     7'h03
`define VFDMX_ADDR_LIMIT    7'h0E
// field limits and masks
`define VFDMX_GRID_MAX      8'h2F
`define VFDMX_LIMIT_MAX     8'h53
`define VFDMX_POL_BIT       1
`define VFDMX_POL_MASK      8'h02
`define VFDMX_BRIGHT_TOP    4'hE
// reset values
`define VFDMX_RST_BRIGHT    8'h00
`define VFDMX_RST_GRID      8'h00
`define VFDMX_RST_LIMIT     8'h53
`define VFDMX_RST_POL       8'h00
// timing
`define VFDMX_CLK_HZ        40000000
`define VFDMX_OSC_HZ        4000000
`define VFDMX_OSC_DIV       (`VFDMX_CLK_HZ / `VFDMX_OSC_HZ)
`define VFDMX_SHIFT_OSC     4
`define VFDMX_SLOT_NS       6250
`define VFDMX_SLOT_OSC      ((`VFDMX_SLOT_NS * (`VFDMX_OSC_HZ / 1000000)) / 1000)
`define VFDMX_LAST_SLOT     4'hF
`define VFDMX_BLANK_CYCLES  2'h2
`endif

// >>> rtl/vfdmx_pkg.sv
// types shared by the vfd mux command port
// assumes vfdmx_map.svh for every number
package vfdmx_pkg;
	typedef struct packed {
		logic [7:0] brightness;
		logic [7:0] grid;
		logic [7:0] limit;
		logic [7:0] polarity;
	} vfdmx_cfg_s;

	typedef enum logic [1:0] {
		VFDMX_SH_IDLE = 2'b01,
		VFDMX_SH_RUN  = 2'b10
	} vfdmx_sh_e;
endpackage

// >>> tb/vfdmx_host.sv
// host side model of the 4-wire serial command link
// assumes the caller leaves the link idle between calls
`timescale 1ns/1ps

module vfdmx_host (
	// link
	output logic      sclk,
	output logic      cs_n,
	output logic      din,
	input  wire logic dout
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din  = 1'b0;
	end

	// n bits msb first; for n of 16, rd[14:1] holds dout after falls 1..14
	task automatic xfer(input logic [31:0] w, input int n, output logic [15:0] rd);
		rd = 16'h0000;
		sclk = 1'b0;
		#15 cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			din = w[i];
			#15;
			if (i < n - 1)
				rd = {rd[14:0], dout};
			sclk = 1'b1;
			#15;
			if (i > 0)
				sclk = 1'b0;
		end
		cs_n = 1'b1;
		#15 sclk = 1'b0;
		// released line flips so a stale level never looks valid
		din = ~din;
		#150;
	endtask

	// clock pulses while deselected
	task automatic idle_clocks(input int n);
		for (int i = 0; i < n; i++) begin
			din = ~din;
			#15 sclk = 1'b1;
			#15 sclk = 1'b0;
		end
	endtask
endmodule

// >>> tb/vfdmx_top_bench.sv
// self-checking bench of the vfd mux command port
// assumes 40 MHz clk, host link at 30 ns, grid period of 4000 clk
`timescale 1ns/1ps
`include "vfdmx_map.svh"

`define CHK(a, b) begin \
	cmp_count++; \
	if ((a) !== (b)) begin \
		n_fail++; \
		$display("unexpected at %0t: got %0h want %0h", $time, (a), (b)); \
	end \
end

module vfdmx_top_bench;
	logic       clk;
	logic       rst;
	logic       shutdown;
	logic       pol;
	logic       sc_q;
	logic       sd_q;
	logic       ld_q;
	logic [15:0] r;
	wire        sclk, cs_n, din, dout, sc, sd, ld, bl;
	int         n_fail, cmp_count, ticks, cyc, rcyc, sp, rises, unbl, pos, ldw, n_ld;
	int         l_rises, l_unbl, l_pos;

	vfdmx_top u_vfdmx_top (.clk(clk), .rst(rst), .host_sclk(sclk), .host_cs_n(cs_n), .host_din(din),
		.host_dout(dout), .shutdown(shutdown), .tube_shift_clock(sc), .tube_serial_data(sd),
		.tube_latch_load(ld), .tube_blank(bl));
	vfdmx_host u_vfdmx_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// stream monitor, sampled mid-cycle where outputs are settled
	always @(negedge clk) begin
		sc_q <= sc;
		sd_q <= sd;
		ld_q <= ld;
		cyc <= cyc + 1;
		unbl <= unbl + int'(bl === pol);
		if (!rst && sd !== sd_q)
			`CHK(sc_q & ~sc, 1'b1)
		if (!rst && ~ld & ld_q)
			`CHK(bl, ~pol)
		if (ld)
			ldw <= ldw + 1;
		if (sc & ~sc_q) begin
			rises <= rises + 1;
			if (sd)
				pos <= rises;
			// first rise of a stream follows a long idle gap
			if (rises != 0)
				sp <= cyc - rcyc;
			rcyc <= cyc;
		end
		if (ld & ~ld_q) begin
			l_rises <= rises;
			l_unbl <= unbl;
			l_pos <= pos;
			rises <= 0;
			pos <= 99;
			ldw <= 1;
			unbl <= int'(bl === pol);
			n_ld <= n_ld + 1;
		end
	end

	always @(posedge clk) begin
		ticks++;
		if (ticks == 70000) begin
			n_fail++;
			conclude;
		end
	end

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		u_vfdmx_host.xfer({16'h0000, 1'b0, a, d}, 16, r);
	endtask

	// read frame with dummy data, then a no-op frame fetches the result
	task automatic chk_reg(input logic [6:0] a, input logic [7:0] e);
		u_vfdmx_host.xfer({16'h0000, 1'b1, a, 8'hA5}, 16, r);
		u_vfdmx_host.xfer(32'h0, 16, r);
		`CHK(r[14:1], {a, e[7:1]})
	endtask

	// waits k period starts, then lands inside slot 1
	task automatic wait_ld(input int k);
		int n0;
		n0 = n_ld;
		wait (n_ld == n0 + k);
		repeat (300) @(negedge clk);
	endtask

	task automatic t_regs;
		chk_reg(`VFDMX_ADDR_BRIGHT, `VFDMX_RST_BRIGHT);
		chk_reg(`VFDMX_ADDR_GRID, `VFDMX_RST_GRID);
		chk_reg(`VFDMX_ADDR_LIMIT, `VFDMX_RST_LIMIT);
		chk_reg(`VFDMX_ADDR_POL, `VFDMX_RST_POL);
		chk_reg(7'h7F, 8'h00);
		wr(`VFDMX_ADDR_GRID, 8'h40);
		chk_reg(`VFDMX_ADDR_GRID, 8'h2F);
		wr(`VFDMX_ADDR_LIMIT, 8'h54);
		chk_reg(`VFDMX_ADDR_LIMIT, 8'h53);
		wr(`VFDMX_ADDR_LIMIT, 8'h10);
		wr(`VFDMX_ADDR_NOOP, 8'h00);
		// deselected pulses between read and fetch must not shift the result
		u_vfdmx_host.xfer({16'h0000, 1'b1, `VFDMX_ADDR_LIMIT, 8'hA5}, 16, r);
		u_vfdmx_host.idle_clocks(5);
		u_vfdmx_host.xfer(32'h0, 16, r);
		`CHK(r[14:1], {`VFDMX_ADDR_LIMIT, 7'h08})
		u_vfdmx_host.xfer({12'h000, 4'hF, 1'b0, `VFDMX_ADDR_GRID, 8'h02}, 20, r);
		chk_reg(`VFDMX_ADDR_GRID, 8'h02);
		$display("test regs done");
	endtask

	task automatic t_tube;
		int p[3];
		wr(`VFDMX_ADDR_BRIGHT, 8'h03);
		wait_ld(3);
		for (int i = 0; i < 3; i++) begin
			wait_ld(1);
			p[i] = l_pos;
			`CHK(l_rises, 8'h10 + 1)
			`CHK(l_unbl, 4 * 250)
			`CHK(ldw, 40)
			`CHK(sp, 40)
		end
		`CHK(p[1], (p[0] + 1) % 3)
		`CHK(p[2], (p[1] + 1) % 3)
		`CHK(p[0], (p[2] + 1) % 3)
		$display("test tube done");
	endtask

	task automatic t_bright;
		wr(`VFDMX_ADDR_BRIGHT, 8'h0F);
		wr(`VFDMX_ADDR_POL, `VFDMX_POL_MASK);
		pol = 1'b1;
		wait_ld(2);
		`CHK(l_unbl, 15 * 250)
		`CHK(bl, 1'b1)
		$display("test bright done");
	endtask

	task automatic t_shut;
		int n0;
		int on;
		shutdown = 1'b1;
		repeat (60) @(negedge clk);
		n0 = n_ld;
		on = 0;
		repeat (4500) begin
			@(negedge clk);
			on += int'(bl === pol);
		end
		`CHK(on, 0)
		`CHK(n_ld, n0)
		shutdown = 1'b0;
		wait_ld(3);
		`CHK(l_rises, 8'h10 + 1)
		$display("test shutdown done");
	endtask

	initial begin
		rst = 1'b1;
		shutdown = 1'b0;
		pol = 1'b0;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		t_regs;
		t_tube;
		t_bright;
		t_shut;
		conclude;
	end
endmodule
